// ### src/tx_pkg.sv
// constants and types shared by the serial transmitter files
package tx_pkg;
   // ****************************************
   // frame geometry
   // ****************************************
   localparam int FRAME_W = 12;
   localparam int LEN_W = 4;
   localparam logic [3:0] LEN_8BIT = 4'hA;
   localparam logic [3:0] LEN_9BIT = 4'hB;
   localparam logic [3:0] LEN_TAIL = 4'h1;
   localparam logic [3:0] LEN_LAST = 4'h1;
   localparam logic [11:0] FRAME_ONES = 12'hFFF;
   localparam logic [11:0] FRAME_ZEROS = 12'h000;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic RST_EMPTY_FLAG = 1'b1;
   localparam logic RST_COMPLETE_FLAG = 1'b1;
   localparam logic RST_LINE = 1'b1;

   // ****************************************
   // kind of frame offered to the shifter
   // ****************************************
   typedef enum logic [2:0] {
      SRC_NONE = 3'h0,
      SRC_PRE = 3'h1,
      SRC_BRK = 3'h2,
      SRC_TAIL = 3'h3,
      SRC_DATA = 3'h4
   } src_t;
endpackage : tx_pkg

// ### src/tx_link_if.sv
// frame hand-off between transmit control and frame shifter
`timescale 1ns/100ps
interface tx_link_if;
   logic tick;
   logic req;
   logic [11:0] frame;
   logic [3:0] len;
   logic take;
   logic done;
   logic busy;
   logic line;

   modport shifter (input tick, input req, input frame, input len,
                    output take, output done, output busy, output line);
   modport ctrl (output tick, output req, output frame, output len,
                 input take, input done, input busy, input line);
endinterface : tx_link_if

// ### src/tx_frame_shifter.sv
// shift register that sends one frame lsb first, one bit per baud tick
`timescale 1ns/100ps
module tx_frame_shifter (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // frame hand-off
   tx_link_if.shifter link
);
   logic [11:0] sh_q;
   logic [3:0] cnt_q;
   logic busy_q;
   logic line_q;

   // ****************************************
   // boundary decode
   // ****************************************
   // a bit boundary where the shifter may accept a new frame
   wire last_bit = busy_q && (cnt_q == tx_pkg::LEN_LAST);
   wire free_slot = !busy_q || last_bit;
   assign link.take = link.tick && free_slot && link.req;
   assign link.done = link.tick && last_bit;
   assign link.busy = busy_q;
   assign link.line = line_q;

   // ****************************************
   // shift engine
   // ****************************************
   // one bit per tick
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         sh_q <= tx_pkg::FRAME_ONES;
         cnt_q <= '0;
         busy_q <= 1'b0;
         line_q <= tx_pkg::RST_LINE;
      end else if (link.tick) begin
         if (!free_slot) begin
            sh_q <= {1'b1, sh_q[11:1]};
            cnt_q <= cnt_q - 4'h1;
            line_q <= sh_q[1];
         end else if (link.req) begin
            sh_q <= link.frame;
            cnt_q <= link.len;
            busy_q <= 1'b1;
            line_q <= link.frame[0];
         end else begin
            busy_q <= 1'b0;
            line_q <= tx_pkg::RST_LINE;
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   a_bit_hold: assert property (!link.tick |=> $stable(line_q))
      else $error("line changed without a baud tick");
   a_idle_high: assert property (!busy_q |-> line_q)
      else $error("line low while shifter idle");
endmodule : tx_frame_shifter

// ### src/async_serial_transmitter.sv
// transmit half of an asynchronous nrz serial port with holding buffer
// Function
// - word length select picks 8 data bits when clear, 9 when set
// - serial output is low for the whole start bit
// - serial output is high for the whole stop bit
// - idle character is 10 or 11 bit times of continuous high
// - break is 10 or 11 low bits, then one extra high bit
// - ninth bit field is sent as the last data bit in 9-bit mode
// - data bits leave least significant bit first
// - raising transmit enable first sends a 10 or 11 ones preamble
// - empty flag clears only by status access then data write
// - empty flag sets when holding buffer moves into the shifter
// - empty interrupt while flag, its enable and unmasked cpu
// - write during transmission waits in holding buffer for frame end
// - write while idle starts at once and empty flag stays set
// - complete flag sets after stop bit; interrupt when enabled, unmasked
// - complete flag clear begins with status access, stays set until write
// - complete flag clears by the same status then write pair
// - breaks repeat while requested, one high bit follows the last
// - enable toggled mid-frame: preamble after word, buffer discarded
// - enabled and idle rests high; disabled releases the pin after any frame in progress ends
`timescale 1ns/100ps
module async_serial_transmitter (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // baud rate generator
   input wire logic baud_tick,
   // cpu accesses
   input wire logic status_access,
   input wire logic data_write,
   input wire logic [7:0] data_in,
   // configuration
   input wire logic word_len_9,
   input wire logic tx_ninth_bit,
   input wire logic tx_enable_bit,
   input wire logic send_break_request,
   input wire logic tx_empty_irq_enable,
   input wire logic tx_complete_irq_enable,
   input wire logic [1:0] cpu_irq_mask,
   // serial pin
   output logic tx_out,
   output logic tx_out_en,
   // status and interrupts
   output logic tx_buffer_empty_flag,
   output logic tx_complete_flag,
   output logic tx_empty_irq,
   output logic tx_complete_irq
);
   tx_link_if link ();

   tx_frame_shifter u_shift (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .link(link.shifter)
   );

   logic enable_q;
   logic pre_q;
   logic brk_tail_q;
   logic hold_v_q;
   logic [8:0] hold_q;
   logic empty_flag_q;
   logic complete_flag_q;
   logic armed_q;
   tx_pkg::src_t cur_q;
   tx_pkg::src_t sel;
   logic [11:0] frame_sel;
   logic [3:0] len_sel;

   // ****************************************
   // decode
   // ****************************************
   // enable rise, idle state and the armed write
   wire enable_rise = tx_enable_bit && !enable_q;
   wire idle_now = !link.busy && !hold_v_q && !pre_q;
   wire clear_write = data_write && armed_q;
   wire take_data = link.take && (sel == tx_pkg::SRC_DATA);
   wire take_brk = link.take && (sel == tx_pkg::SRC_BRK);
   wire take_tail = link.take && (sel == tx_pkg::SRC_TAIL);
   wire take_pre = link.take && (sel == tx_pkg::SRC_PRE);
   wire line_done = link.done && !link.take;
   // length sampled when frame is taken
   wire [3:0] char_len = word_len_9 ? tx_pkg::LEN_9BIT : tx_pkg::LEN_8BIT;
   wire ninth_or_stop = word_len_9 ? hold_q[8] : 1'b1;

   // source priority: preamble, break, break tail, data
   assign sel = !tx_enable_bit ? tx_pkg::SRC_NONE :
                pre_q ? tx_pkg::SRC_PRE :
                send_break_request ? tx_pkg::SRC_BRK :
                brk_tail_q ? tx_pkg::SRC_TAIL :
                hold_v_q ? tx_pkg::SRC_DATA : tx_pkg::SRC_NONE;
   assign link.tick = baud_tick;
   assign link.req = (sel != tx_pkg::SRC_NONE);
   assign link.frame = frame_sel;
   assign link.len = len_sel;

   // ****************************************
   // frame builder
   // ****************************************
   // picks frame pattern and length for the selected source
   always_comb begin
      frame_sel = tx_pkg::FRAME_ONES;
      len_sel = char_len;
      case (sel)
         tx_pkg::SRC_PRE: begin
            frame_sel = tx_pkg::FRAME_ONES;
         end
         tx_pkg::SRC_BRK: begin
            frame_sel = tx_pkg::FRAME_ZEROS;
         end
         tx_pkg::SRC_TAIL: begin
            len_sel = tx_pkg::LEN_TAIL;
         end
         // start, data lsb first, ninth, stop
         tx_pkg::SRC_DATA: begin
            frame_sel = {2'b11, ninth_or_stop, hold_q[7:0], 1'b0};
         end
         default: begin
            frame_sel = tx_pkg::FRAME_ONES;
         end
      endcase
   end

   // ****************************************
   // sequencing
   // ****************************************
   // preamble pending on each enable rise
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         enable_q <= 1'b0;
         pre_q <= 1'b0;
      end else begin
         enable_q <= tx_enable_bit;
         if (enable_rise) begin
            pre_q <= 1'b1;
         end else if (take_pre || !tx_enable_bit) begin
            pre_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         brk_tail_q <= 1'b0;
      end else if (take_brk) begin
         brk_tail_q <= 1'b1;
      end else if (take_tail || !tx_enable_bit) begin
         brk_tail_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         hold_v_q <= 1'b0;
         hold_q <= '0;
      end else if (!tx_enable_bit) begin
         hold_v_q <= 1'b0;
      end else if (data_write) begin
         hold_v_q <= 1'b1;
         hold_q <= {tx_ninth_bit, data_in};
      end else if (take_data) begin
         hold_v_q <= 1'b0;
      end
   end

   // ****************************************
   // flags
   // ****************************************
   // status access arms the next data write
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         armed_q <= 1'b0;
      end else if (status_access) begin
         armed_q <= 1'b1;
      end else if (data_write) begin
         armed_q <= 1'b0;
      end
   end

   // set wins over the armed write
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         empty_flag_q <= tx_pkg::RST_EMPTY_FLAG;
      end else if (take_data || !tx_enable_bit || (data_write && idle_now)) begin
         empty_flag_q <= 1'b1;
      end else if (clear_write) begin
         empty_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         complete_flag_q <= tx_pkg::RST_COMPLETE_FLAG;
      end else if (line_done) begin
         complete_flag_q <= 1'b1;
      end else if (clear_write) begin
         complete_flag_q <= 1'b0;
      end
   end

   // kind of frame now on the line
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cur_q <= tx_pkg::SRC_NONE;
      end else if (link.take) begin
         cur_q <= sel;
      end else if (line_done) begin
         cur_q <= tx_pkg::SRC_NONE;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // pin driven while enabled or a frame finishes
   assign tx_out = link.line;
   assign tx_out_en = tx_enable_bit || link.busy;
   assign tx_buffer_empty_flag = empty_flag_q;
   assign tx_complete_flag = complete_flag_q;
   assign tx_empty_irq = empty_flag_q && tx_empty_irq_enable && (cpu_irq_mask == 2'h0);
   assign tx_complete_irq = complete_flag_q && tx_complete_irq_enable &&
                            (cpu_irq_mask == 2'h0);

   // ****************************************
   // checks
   // ****************************************
   // helper that replays the last data frame bit by bit
   logic chk_v_q;
   logic [11:0] chk_frame_q;
   logic [3:0] chk_idx_q;
   logic [3:0] chk_len_q;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         chk_v_q <= 1'b0;
         chk_frame_q <= '0;
         chk_idx_q <= '0;
         chk_len_q <= '0;
      end else if (take_data) begin
         chk_v_q <= 1'b1;
         chk_frame_q <= link.frame;
         chk_idx_q <= '0;
         chk_len_q <= link.len;
      end else if (baud_tick && chk_v_q) begin
         chk_v_q <= (chk_idx_q != (chk_len_q - 4'h1));
         chk_idx_q <= chk_idx_q + 4'h1;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   sequence s_arm_then_write;
      status_access ##1 (data_write && !status_access && !link.take && !idle_now &&
                         tx_enable_bit);
   endsequence
   sequence s_data_start;
      take_data && !word_len_9;
   endsequence

   a_frame_bits: assert property (chk_v_q |-> tx_out == chk_frame_q[chk_idx_q])
      else $error("serial bit differs from frame order");
   a_len_eight: assert property (s_data_start |-> link.len == 4'hA)
      else $error("8-bit frame not ten bits long");
   a_start_low: assert property (take_data |=> !tx_out ##0 chk_idx_q == 4'h0)
      else $error("start bit not low");
   // stop bit high at frame end
   a_stop_high: assert property (link.done && cur_q == tx_pkg::SRC_DATA |-> tx_out)
      else $error("stop bit not high");
   // status then write clears empty flag
   a_clear_pair: assert property (s_arm_then_write |=> !tx_buffer_empty_flag)
      else $error("empty flag not cleared by access pair");
   // empty flag on move to shifter
   a_empty_take: assert property (take_data |=> tx_buffer_empty_flag)
      else $error("empty flag not set on transfer");
   a_direct_write: assert property (data_write && idle_now |=> tx_buffer_empty_flag)
      else $error("empty flag low after idle write");
   a_complete_set: assert property (line_done |=> tx_complete_flag ##0 !link.busy)
      else $error("complete flag missing after stop bit");
   a_complete_hold: assert property (tx_complete_flag && !data_write |=> tx_complete_flag)
      else $error("complete flag dropped without data write");
   a_preamble_len: assert property (take_pre |-> link.len == char_len && &link.frame)
      else $error("preamble length wrong");
   a_break_tail: assert property (take_tail |=> tx_out ##0 !brk_tail_q)
      else $error("break tail not a single high bit");
   a_discard: assert property (!tx_enable_bit |=> !hold_v_q)
      else $error("holding buffer kept while disabled");
endmodule : async_serial_transmitter

// ### testbench/serial_node_model.sv
// remote serial node model: samples the transmit line once per bit time
`timescale 1ns/100ps
module serial_node_model (
   // clock
   input wire logic clk_sys,
   // serial line
   input wire logic baud_tick,
   input wire logic tx_out,
   input wire logic tx_out_en,
   // captured history, newest bit in position 0
   output logic [63:0] line_hist_q
);
   // released pin reads high through the pull-up
   wire logic line_level = tx_out_en ? tx_out : 1'b1;
   always_ff @(posedge clk_sys) begin
      if (baud_tick) begin
         line_hist_q <= {line_hist_q[62:0], line_level};
      end
   end
endmodule : serial_node_model

// ### testbench/testbench.sv
// self-checking bench for the serial transmitter
`timescale 1ns/100ps
module testbench;
   // ****************************************
   // signals
   // ****************************************
   logic clk_sys, rstn, baud_tick, status_access, data_write, word_len_9, tx_ninth_bit;
   logic tx_enable_bit, send_break_request, tx_empty_irq_enable, tx_complete_irq_enable;
   logic [7:0] data_in;
   logic [1:0] cpu_irq_mask, div_q;
   logic tx_out, tx_out_en, tx_buffer_empty_flag, tx_complete_flag;
   logic tx_empty_irq, tx_complete_irq;
   logic [63:0] line_hist;
   int errors, n_checks;

   async_serial_transmitter async_serial_transmitter_i (.clk_sys(clk_sys), .rstn(rstn),
      .baud_tick(baud_tick), .status_access(status_access), .data_write(data_write),
      .data_in(data_in), .word_len_9(word_len_9), .tx_ninth_bit(tx_ninth_bit),
      .tx_enable_bit(tx_enable_bit), .send_break_request(send_break_request),
      .tx_empty_irq_enable(tx_empty_irq_enable),
      .tx_complete_irq_enable(tx_complete_irq_enable), .cpu_irq_mask(cpu_irq_mask),
      .tx_out(tx_out), .tx_out_en(tx_out_en), .tx_buffer_empty_flag(tx_buffer_empty_flag),
      .tx_complete_flag(tx_complete_flag), .tx_empty_irq(tx_empty_irq),
      .tx_complete_irq(tx_complete_irq));
   serial_node_model serial_node_model_i (.clk_sys(clk_sys), .baud_tick(baud_tick),
      .tx_out(tx_out), .tx_out_en(tx_out_en), .line_hist_q(line_hist));

   // ****************************************
   // clock, baud tick and watchdog
   // ****************************************
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // one bit time every four clocks
   always @(posedge clk_sys) begin
      div_q <= div_q + 2'h1;
      baud_tick <= (div_q == 2'h3);
   end
   initial begin
      #400000;
      errors++;
      give_verdict();
   end

   // ****************************************
   // helpers
   // ****************************************
   task automatic check_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_bit
   task automatic check_bits(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_bits
   // status access then data write, one cycle apart
   task automatic write_pair(input logic [7:0] d, input logic b8);
      @(posedge clk_sys) status_access <= 1'b1;
      @(posedge clk_sys) status_access <= 1'b0;
      data_write <= 1'b1;
      data_in <= d;
      tx_ninth_bit <= b8;
      @(posedge clk_sys) data_write <= 1'b0;
      @(posedge clk_sys);
   endtask : write_pair
   task automatic wait_ticks(input int n);
      repeat (n * 4) @(posedge clk_sys);
   endtask : wait_ticks
   task automatic wait_complete;
      int i;
      i = 0;
      while (tx_complete_flag !== 1'b1 && i < 400) begin
         @(posedge clk_sys);
         i++;
      end
      if (i >= 400) errors++;
      @(posedge clk_sys);
   endtask : wait_complete
   // expected line bits, start bit highest, stop bit in position 0
   function automatic logic [10:0] frame_bits(input logic [7:0] d, input logic nine,
                                              input logic b8);
      logic [10:0] e;
      e = '1;
      e[nine ? 10 : 9] = 1'b0;
      for (int i = 0; i < 8; i++) e[(nine ? 9 : 8) - i] = d[i];
      if (nine) e[1] = b8;
      return e;
   endfunction : frame_bits

   // ****************************************
   // scenarios
   // ****************************************
   task automatic test_reset;
      check_bit(tx_out, 1'b1);
      check_bit(tx_out_en, 1'b0);
      check_bit(tx_buffer_empty_flag, 1'b1);
      check_bit(tx_complete_flag, 1'b1);
      $display("test reset done");
   endtask : test_reset
   task automatic test_preamble_byte;
      logic [10:0] fb;
      fb = frame_bits(8'hA5, 1'b0, 1'b0);
      @(posedge clk_sys) tx_enable_bit <= 1'b1;
      tx_empty_irq_enable <= 1'b1;
      tx_complete_irq_enable <= 1'b1;
      write_pair(8'hA5, 1'b0);
      check_bit(tx_buffer_empty_flag, 1'b0);
      check_bit(tx_complete_flag, 1'b0);
      check_bit(tx_empty_irq, 1'b0);
      wait_ticks(12);
      check_bit(tx_buffer_empty_flag, 1'b1);
      check_bit(tx_empty_irq, 1'b1);
      cpu_irq_mask <= 2'h2;
      @(posedge clk_sys);
      check_bit(tx_empty_irq, 1'b0);
      wait_complete();
      check_bits(line_hist[19:0], {10'h3FF, fb[9:0]});
      check_bit(tx_complete_irq, 1'b0);
      cpu_irq_mask <= 2'h0;
      @(posedge clk_sys);
      check_bit(tx_complete_irq, 1'b1);
      $display("test preamble and byte done");
   endtask : test_preamble_byte
   task automatic test_nine_bit_idle;
      @(posedge clk_sys) word_len_9 <= 1'b1;
      wait_ticks(2);
      write_pair(8'h3C, 1'b1);
      check_bit(tx_buffer_empty_flag, 1'b1);
      check_bit(tx_complete_flag, 1'b0);
      wait_complete();
      check_bits(line_hist[10:0], frame_bits(8'h3C, 1'b1, 1'b1));
      $display("test nine bit done");
   endtask : test_nine_bit_idle
   task automatic test_break;
      int z, run;
      @(posedge clk_sys) word_len_9 <= 1'b0;
      send_break_request <= 1'b1;
      wait_ticks(25);
      send_break_request <= 1'b0;
      wait_ticks(16);
      z = 0;
      while (z < 40 && line_hist[z] === 1'b1) z++;
      run = 0;
      while (z + run < 64 && line_hist[z + run] === 1'b0) run++;
      // whole break characters, at least two, before the trailing high bits
      check_bits(64'(run % 10), 64'h0);
      check_bit(run >= 20, 1'b1);
      $display("test break done");
   endtask : test_break
   task automatic test_disable;
      @(posedge clk_sys) tx_enable_bit <= 1'b0;
      @(posedge clk_sys);
      check_bit(tx_out_en, 1'b0);
      $display("test disable done");
   endtask : test_disable

   // ****************************************
   // verdict and main sequence
   // ****************************************
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      errors = 0;
      n_checks = 0;
      rstn = 1'b0;
      div_q = 2'h0;
      baud_tick = 1'b0;
      status_access = 1'b0;
      data_write = 1'b0;
      data_in = 8'h00;
      word_len_9 = 1'b0;
      tx_ninth_bit = 1'b0;
      tx_enable_bit = 1'b0;
      send_break_request = 1'b0;
      tx_empty_irq_enable = 1'b0;
      tx_complete_irq_enable = 1'b0;
      cpu_irq_mask = 2'h0;
      repeat (4) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      test_reset();
      // length and baud settled before enable
      test_preamble_byte();
      test_nine_bit_idle();
      test_break();
      test_disable();
      give_verdict();
   end
endmodule : testbench
